// ===== bench/sleep_state_power_control_test.sv
// Self-checking bench for the sleep-state power control block
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.svh"
module sleep_state_power_control_test;
   logic mclk = 1'b0, rst_n = 1'b0, moff = 1'b0, mneed = 1'b1, wal = 1'b0, espi = 1'b0, tmode = 1'b0;
   logic hold = 1'b0, rreq = 1'b0, alrt = 1'b0, wreq = 1'b0, tsd = 1'b0;
   logic [`SSPC_TIME_W-1:0] tmatch = '0, tcap;
   sspc_pkg::sspc_sys_t st = sspc_pkg::SYS_S0;
   sspc_pkg::sspc_sleep_t sp;
   logic rtc, sclk, ack, done, fse, irst, tso, tsoe, thr, wev, wo_n, woe, hold_n, rq_n, tsi, al_n, wk_n, lanp, dramp;
   logic [3:0] h;
   int n_mismatch = 0, num_checks = 0, cnt = 0;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) h <= {h[2:0], rtc};
   always @(posedge mclk) cnt <= rst_n ? cnt + 1 : 0;
   sspc_ctrl u_sspc_ctrl (.mclk(mclk), .rst_n(rst_n), .sys_state_req(st), .mgmt_off(moff),
      .mgmt_needs_primary(mneed), .wireless_sleep_allow(wal), .espi_enable(espi), .rtc_clk(rtc),
      .sleep_exit_hold_n(hold_n), .system_reset_req_n(rq_n), .time_sync_in(tsi), .time_sync_out_mode(tmode),
      .time_match(tmatch), .regulator_alert_n(al_n), .wake_in_n(wk_n), .sleep_pins(sp), .suspend_clock_out(sclk),
      .primary_well_down_ack(ack), .sleep_exit_done(done), .flash_share_en(fse), .internal_reset(irst),
      .time_sync_out(tso), .time_sync_oe(tsoe), .time_captured(tcap), .throttle_req(thr), .wake_event(wev),
      .wake_out_n(wo_n), .wake_oe(woe));
   sspc_platform u_sspc_platform (.hold_req(hold), .reset_req(rreq), .alert_req(alrt), .wake_req(wreq),
      .ts_drive(tsd), .wake_out_n(wo_n), .wake_oe(woe), .time_sync_out(tso), .time_sync_oe(tsoe),
      .sleep_pins(sp), .rtc_clk(rtc), .sleep_exit_hold_n(hold_n), .system_reset_req_n(rq_n),
      .regulator_alert_n(al_n), .wake_in_n(wk_n), .time_sync_in(tsi), .lan_powered(lanp), .dram_powered(dramp));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic t_states();
      sspc_pkg::sspc_sys_t s;
      for (int i = 0; i < 4; i++)
      begin
         s = (i == 0) ? sspc_pkg::SYS_S0 : sspc_pkg::sspc_sys_t'(i + 1);
         st = s;
         cyc(2);
         chk(sp.plane_s5_sleep_n, s != sspc_pkg::SYS_S5, "s5 plane");
         chk({sp.plane_s4_sleep_n, dramp}, {2{s < sspc_pkg::SYS_S4}}, "s4 plane");
         chk(sp.plane_s3_sleep_n, s == sspc_pkg::SYS_S0, "s3 plane");
      end
      moff = 1'b1;
      wal = 1'b1;
      cyc(2);
      chk({sp.mgmt_power_sleep_n, sp.wireless_power_sleep_n, sp.lan_power_sleep_n, lanp}, 4'h0, "sleep outputs asserted");
      st = sspc_pkg::SYS_S0;
      cyc(2);
      chk({sp.lan_power_sleep_n, sp.wireless_power_sleep_n, lanp}, 3'h7, "lan and wireless in S0");
      moff = 1'b0;
      st = sspc_pkg::SYS_S5;
      cyc(2);
      chk({sp.lan_power_sleep_n, sp.mgmt_power_sleep_n}, 2'h3, "lan while mgmt awake");
      st = sspc_pkg::SYS_S0;
      wal = 1'b0;
   endtask : t_states
   task automatic t_ack();
      for (int i = 0; i < 4; i++)
      begin
         {moff, mneed} = 2'(i);
         espi = i[0];
         cyc(2);
         chk(ack, moff & ~mneed, "primary ack");
         chk(fse, !espi, "flash share");
      end
      moff = 1'b0;
   endtask : t_ack
   task automatic t_suspend_clock_out();
      int tg = 0;
      logic last = sclk;
      for (int i = 0; i < 80; i++)
      begin
         cyc(1);
         chk(sclk === h[2] || sclk === h[3], 1'b1, "suspend clock copy");
         tg += (sclk !== last);
         last = sclk;
      end
      chk(tg > 8, 1'b1, "suspend clock toggles");
   endtask : t_suspend_clock_out
   task automatic t_holdoff();
      int np = 0;
      espi = 1'b1;
      moff = 1'b1;
      hold = 1'b1;
      cyc(4);
      moff = 1'b0;
      for (int i = 0; i < 30; i++)
      begin
         if (i == 20)
            chk(np, 0, "exit held off");
         hold = (i < 20);
         cyc(1);
         np += (done === 1'b1);
      end
      chk(np, 1, "one exit pulse after release");
   endtask : t_holdoff
   task automatic t_rstreq();
      int n = 0;
      int hi = 0;
      rreq = 1'b1;
      cyc(150);
      rreq = 1'b0;
      cyc(3);
      rreq = 1'b1;
      for (int i = 0; i < 150; i++)
      begin
         cyc(1);
         hi += (irst === 1'b1);
      end
      chk(hi, 0, "glitch restarts debounce");
      while (irst !== 1'b1 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk(n >= 48 && n <= 60, 1'b1, "debounce length");
      if (n == 100)
         conclude();
      rreq = 1'b0;
      cyc(5);
      chk(irst, 1'b0, "reset released");
   endtask : t_rstreq
   task automatic t_tsync();
      int t = cnt;
      logic v;
      tsd = 1'b1;
      cyc(8);
      chk(tcap + 3 >= t && tcap <= t + 6, 1'b1, "time captured");
      tsd = 1'b0;
      tmode = 1'b1;
      tmatch = 32'(cnt + 40);
      cyc(2);
      v = tso;
      chk(tsoe, 1'b1, "pin driven");
      cyc(30);
      chk(tso, v, "no early toggle");
      cyc(20);
      chk(tso, !v, "toggle on match");
      tmode = 1'b0;
   endtask : t_tsync
   task automatic t_alert_wake();
      alrt = 1'b1;
      cyc(1);
      chk(thr, 1'b0, "two sync stages");
      cyc(3);
      chk(thr, 1'b1, "throttle");
      alrt = 1'b0;
      st = sspc_pkg::SYS_S3;
      wreq = 1'b1;
      cyc(4);
      chk({thr, wev, woe}, 3'h2, "wake input in sleep");
      wreq = 1'b0;
      st = sspc_pkg::SYS_ACTIVE_IDLE_STATE;
      cyc(4);
      chk({woe, wo_n, wev}, 3'h4, "wake driven in idle");
      wreq = 1'b1;
      cyc(4);
      chk(wev, 1'b0, "no wake in idle");
      wreq = 1'b0;
      st = sspc_pkg::SYS_S0;
   endtask : t_alert_wake
   initial
   begin
      cyc(1);
      chk(sp, 6'h0, "pins low in reset");
      cyc(1);
      rst_n = 1'b1;
      t_states();
      t_ack();
      t_suspend_clock_out();
      t_holdoff();
      t_rstreq();
      t_tsync();
      t_alert_wake();
      conclude();
   end
endmodule : sleep_state_power_control_test
`default_nettype wire

// ===== bench/sspc_platform.sv
// Platform model: power switches, regulators, wake devices and RTC source
`timescale 1ns/1ps
`default_nettype none
module sspc_platform
#(parameter real RTC_HALF_NS = 30.52)
(
   input  wire logic                  hold_req,
   input  wire logic                  reset_req,
   input  wire logic                  alert_req,
   input  wire logic                  wake_req,
   input  wire logic                  ts_drive,
   input  wire logic                  wake_out_n,
   input  wire logic                  wake_oe,
   input  wire logic                  time_sync_out,
   input  wire logic                  time_sync_oe,
   input  wire sspc_pkg::sspc_sleep_t sleep_pins,
   output var  logic                  rtc_clk,
   output logic                       sleep_exit_hold_n,
   output logic                       system_reset_req_n,
   output logic                       regulator_alert_n,
   output logic                       wake_in_n,
   output logic                       time_sync_in,
   output logic                       lan_powered,
   output logic                       dram_powered
);
   // Runs free; half period chosen so no edge ever lands on a rising mclk edge
   initial rtc_clk = 1'b0;
   always #(RTC_HALF_NS) rtc_clk = ~rtc_clk;
   assign sleep_exit_hold_n  = ~hold_req;
   assign system_reset_req_n = ~reset_req;
   assign regulator_alert_n  = ~alert_req;
   // Pulled up; low while any party pulls it
   assign wake_in_n          = ~(wake_req | (wake_oe & ~wake_out_n));
   assign time_sync_in       = time_sync_oe ? time_sync_out : ts_drive;
   // Power is only removed while the control is asserted
   assign lan_powered        = sleep_pins.lan_power_sleep_n;
   assign dram_powered       = sleep_pins.plane_s4_sleep_n;
endmodule : sspc_platform
`default_nettype wire

// ===== core/sspc_ctrl.sv
// Sleep-state power control pins: sleep plane outputs, wake, reset request, time sync
// Overview of operation
// - LAN sleep output stays high in S0 and whenever management sleep is high.
// - Wireless sleep output may go low to cut power; always high in S0.
// - S3 plane output is asserted in S3, S4 and S5.
// - S4 plane output asserted in S4 and S5; platform uses it for DRAM.
// - S5 plane output asserted only in S5.
// - Suspend clock output is a buffered copy of the RTC clock.
// - Primary-well ack high only when management no longer needs primary well.
// - Holdoff input postpones sleep exit after management sleep de-asserts.
// - With eSPI enabled, flash sharing drops but holdoff still delays exit.
// - Reset request input is debounced; stable assertion forces internal reset.
// - Time sync input edge captures current time counter.
// - Time sync output toggles when counter hits programmed match.
// - Regulator alert input demands processor throttling.
// - Wake line is an input in sleep states.
// - Wake line is driven as output in active-idle states.
// - Management sleep asserted when management is off.
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.svh"
module sspc_ctrl
(
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire sspc_pkg::sspc_sys_t        sys_state_req,
   input  wire logic                       mgmt_off,
   input  wire logic                       mgmt_needs_primary,
   input  wire logic                       wireless_sleep_allow,
   input  wire logic                       espi_enable,
   input  wire logic                       rtc_clk,
   input  wire logic                       sleep_exit_hold_n,
   input  wire logic                       system_reset_req_n,
   input  wire logic                       time_sync_in,
   input  wire logic                       time_sync_out_mode,
   input  wire logic [`SSPC_TIME_W-1:0]    time_match,
   input  wire logic                       regulator_alert_n,
   input  wire logic                       wake_in_n,
   output var  sspc_pkg::sspc_sleep_t      sleep_pins,
   output logic                            suspend_clock_out,
   output logic                            primary_well_down_ack,
   output logic                            sleep_exit_done,
   output logic                            flash_share_en,
   output logic                            internal_reset,
   output logic                            time_sync_out,
   output logic                            time_sync_oe,
   output logic [`SSPC_TIME_W-1:0]         time_captured,
   output logic                            throttle_req,
   output logic                            wake_event,
   output logic                            wake_out_n,
   output logic                            wake_oe
);
   logic [`SSPC_SYNC_W-1:0]  sync_a, sync_b;
   logic [`SSPC_SYNC_W-1:0]  next_sync_a, next_sync_b;
   logic                     rtc_a, rtc_b;
   sspc_pkg::sspc_sleep_t    next_sleep_pins;
   sspc_pkg::sspc_exit_t     exit_st, next_exit_st;
   logic                     next_exit_done, next_ack, next_throttle, next_wake_event, next_wake_oe, next_wake_out_n;
   logic [`SSPC_DBW-1:0]     db_cnt, next_db_cnt;
   logic                     next_internal_reset, next_flash;
   logic [`SSPC_TIME_W-1:0]  tcount, next_tcount, next_captured;
   logic                     ts_prev, next_ts_prev, next_ts_out, next_ts_oe;
   logic                     mgmt_sleep_prev, next_mgmt_sleep_prev;
   logic                     in_s0;

   // Two-stage synchronisers; only the second stage is read by logic
   always_comb
   begin
      next_sync_a = {~wake_in_n, ~regulator_alert_n, time_sync_in, ~system_reset_req_n, ~sleep_exit_hold_n};
      next_sync_b = sync_a;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
      end
   end

   // Sleep plane decode
   always_comb
   begin
      in_s0 = (sys_state_req == sspc_pkg::SYS_S0) || (sys_state_req == sspc_pkg::SYS_ACTIVE_IDLE_STATE);
      next_sleep_pins.mgmt_power_sleep_n     = ~mgmt_off;
      next_sleep_pins.lan_power_sleep_n      = in_s0 || !mgmt_off;
      next_sleep_pins.wireless_power_sleep_n = in_s0 || !wireless_sleep_allow;
      next_sleep_pins.plane_s3_sleep_n       = !((sys_state_req == sspc_pkg::SYS_S3)
                                                 || (sys_state_req == sspc_pkg::SYS_S4)
                                                 || (sys_state_req == sspc_pkg::SYS_S5));
      next_sleep_pins.plane_s4_sleep_n       = !((sys_state_req == sspc_pkg::SYS_S4)
                                                 || (sys_state_req == sspc_pkg::SYS_S5));
      next_sleep_pins.plane_s5_sleep_n       = !(sys_state_req == sspc_pkg::SYS_S5);
      next_ack        = mgmt_off && !mgmt_needs_primary;
      next_throttle   = sync_b[`SSPC_S_ALERT];
      next_wake_oe    = (sys_state_req == sspc_pkg::SYS_ACTIVE_IDLE_STATE);
      next_wake_event = !next_wake_oe && !in_s0 && sync_b[`SSPC_S_WAKE];
      // Pulled low only while driven, so active idle cannot wake the system
      next_wake_out_n = !next_wake_oe;
      next_flash      = !espi_enable;
   end

   // Sleep exit: holdoff input stretches exit after management sleep releases
   always_comb
   begin
      next_exit_st = exit_st;
      next_exit_done = 1'b0;
      next_mgmt_sleep_prev = sleep_pins.mgmt_power_sleep_n;
      unique case (exit_st)
         sspc_pkg::EX_IDLE:
            if (sleep_pins.mgmt_power_sleep_n && !mgmt_sleep_prev)
               next_exit_st = sspc_pkg::EX_HOLD;
         sspc_pkg::EX_HOLD:
            if (!sync_b[`SSPC_S_HOLD])
               next_exit_st = sspc_pkg::EX_GO;
         sspc_pkg::EX_GO:
         begin
            next_exit_done = 1'b1;
            next_exit_st = sspc_pkg::EX_IDLE;
         end
         default:
            next_exit_st = sspc_pkg::EX_IDLE;
      endcase
   end

   // Reset request debounce: must be stable for the full count
   always_comb
   begin
      next_db_cnt = '0;
      next_internal_reset = 1'b0;
      if (sync_b[`SSPC_S_RST])
      begin
         if (db_cnt == `SSPC_DBW'(`SSPC_DEBOUNCE_CYC))
         begin
            next_db_cnt = db_cnt;
            next_internal_reset = 1'b1;
         end
         else
            next_db_cnt = db_cnt + `SSPC_DBW'(1);
      end
   end

   // Time counter, capture and match toggle
   always_comb
   begin
      next_tcount   = tcount + `SSPC_TIME_W'(1);
      next_ts_prev  = sync_b[`SSPC_S_TSYNC];
      next_captured = time_captured;
      next_ts_out   = time_sync_out;
      next_ts_oe    = time_sync_out_mode;
      if (!time_sync_out_mode && sync_b[`SSPC_S_TSYNC] && !ts_prev)
         next_captured = tcount;
      if (time_sync_out_mode && tcount == time_match)
         next_ts_out = ~time_sync_out;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sleep_pins            <= '0;
         exit_st               <= sspc_pkg::EX_IDLE;
         sleep_exit_done       <= 1'b0;
         mgmt_sleep_prev       <= 1'b0;
         primary_well_down_ack <= 1'b0;
         throttle_req          <= 1'b0;
         wake_event            <= 1'b0;
         wake_oe               <= 1'b0;
         wake_out_n            <= 1'b1;
         flash_share_en        <= 1'b0;
         db_cnt                <= '0;
         internal_reset        <= 1'b0;
         tcount                <= '0;
         ts_prev               <= 1'b0;
         time_captured         <= '0;
         time_sync_out         <= 1'b0;
         time_sync_oe          <= 1'b0;
      end
      else
      begin
         sleep_pins            <= next_sleep_pins;
         exit_st               <= next_exit_st;
         sleep_exit_done       <= next_exit_done;
         mgmt_sleep_prev       <= next_mgmt_sleep_prev;
         primary_well_down_ack <= next_ack;
         throttle_req          <= next_throttle;
         wake_event            <= next_wake_event;
         wake_oe               <= next_wake_oe;
         wake_out_n            <= next_wake_out_n;
         flash_share_en        <= next_flash;
         db_cnt                <= next_db_cnt;
         internal_reset        <= next_internal_reset;
         tcount                <= next_tcount;
         ts_prev               <= next_ts_prev;
         time_captured         <= next_captured;
         time_sync_out         <= next_ts_out;
         time_sync_oe          <= next_ts_oe;
      end
   end

   // Suspend clock is a resampled copy, not divided; limited to mclk resolution
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rtc_a <= 1'b0;
         rtc_b <= 1'b0;
         suspend_clock_out <= 1'b0;
      end
      else
      begin
         rtc_a <= rtc_clk;
         rtc_b <= rtc_a;
         suspend_clock_out <= rtc_b;
      end
   end

   a_lan_in_s0: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(sys_state_req) == sspc_pkg::SYS_S0 |-> sleep_pins.lan_power_sleep_n)
      else $error("LAN sleep asserted in S0");
   a_wlan_in_s0: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(sys_state_req) == sspc_pkg::SYS_S0 |-> sleep_pins.wireless_power_sleep_n)
      else $error("Wireless sleep asserted in S0");
   a_s3_plane: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(sys_state_req) == sspc_pkg::SYS_S4 |-> !sleep_pins.plane_s3_sleep_n)
      else $error("S3 plane not asserted in S4");
   a_s4_plane: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(sys_state_req) == sspc_pkg::SYS_S5 |-> !sleep_pins.plane_s4_sleep_n)
      else $error("S4 plane not asserted in S5");
   a_s5_only: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && !sleep_pins.plane_s5_sleep_n |-> $past(sys_state_req) == sspc_pkg::SYS_S5)
      else $error("S5 plane asserted outside S5");
   a_ack_mgmt: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> primary_well_down_ack == ($past(mgmt_off) && !$past(mgmt_needs_primary)))
      else $error("Ack while management on");
   a_hold_exit: assert property (@(posedge mclk) disable iff (!rst_n)
      exit_st == sspc_pkg::EX_HOLD && sync_b[`SSPC_S_HOLD] |=> exit_st == sspc_pkg::EX_HOLD)
      else $error("Exit left hold while held");
   a_rst_debounce: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(internal_reset) |-> $past(sync_b[`SSPC_S_RST], 2))
      else $error("Internal reset without stable request");
   a_wake_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(sys_state_req) == sspc_pkg::SYS_ACTIVE_IDLE_STATE |-> wake_oe && !wake_event)
      else $error("Wake not driven in active idle");
   a_mgmt_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> sleep_pins.mgmt_power_sleep_n == !$past(mgmt_off))
      else $error("Management sleep not asserted");
endmodule : sspc_ctrl
`default_nettype wire

// ===== pkg/sspc_pkg.sv
// Types for the sleep-state power control block
package sspc_pkg;
   typedef enum logic [2:0] {SYS_S0, SYS_ACTIVE_IDLE_STATE, SYS_S3, SYS_S4, SYS_S5} sspc_sys_t;
   typedef struct packed {
      logic lan_power_sleep_n;
      logic wireless_power_sleep_n;
      logic plane_s3_sleep_n;
      logic plane_s4_sleep_n;
      logic plane_s5_sleep_n;
      logic mgmt_power_sleep_n;
   } sspc_sleep_t;
   typedef enum logic [1:0] {EX_IDLE, EX_HOLD, EX_GO} sspc_exit_t;
endpackage : sspc_pkg

// ===== pkg/sspc_regs.svh
// Constants for the sleep-state power control block
`ifndef SSPC_REGS_SVH
`define SSPC_REGS_SVH
`define SSPC_DEBOUNCE_NS   1000
`define SSPC_CLK_NS        5
`define SSPC_DEBOUNCE_CYC  ((`SSPC_DEBOUNCE_NS + `SSPC_CLK_NS - 1) / `SSPC_CLK_NS)
`define SSPC_DBW           8
`define SSPC_TIME_W        32
`define SSPC_SYNC_W        5
`define SSPC_S_HOLD        0
`define SSPC_S_RST         1
`define SSPC_S_TSYNC       2
`define SSPC_S_ALERT       3
`define SSPC_S_WAKE        4
`endif
